// ### rtl/lui_pkg.sv
// Constants shared by the host control port design files
package lui_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_MASK1 = 8'h11;
   localparam logic [7:0] ADDR_MASK2 = 8'h12;
   localparam logic [7:0] ADDR_STAT1 = 8'h16;
   localparam logic [7:0] ADDR_STAT2 = 8'h17;
   localparam logic [7:0] ADDR_GCFG  = 8'h40;
   localparam logic [7:0] ADDR_SUMM  = 8'h80;
   // Reset values
   localparam logic [7:0] MASK_RST   = 8'hFF;
   localparam logic [7:0] GCFG_RST   = 8'h00;
   localparam logic [7:0] ZERO8      = 8'h00;
   // Global configuration fields
   localparam int         GLB_BIT    = 2;
   localparam int         STYLE_LSB  = 0;
   localparam logic [1:0] STY_OD_LOW = 2'h0;
   localparam logic [1:0] STY_PP_LOW = 2'h1;
   localparam logic [1:0] STY_PP_HI  = 2'h2;
   // Interrupt sources and channels
   localparam int         NSRC       = 16;
   localparam int         NCH        = 4;
   // Reset pin filter: low for more than RST_NS
   localparam int         CLK_NS     = 100;
   localparam int         RST_NS     = 100;
   localparam int         RST_CYC    = RST_NS / CLK_NS + 1;
   localparam logic [1:0] RST_CNT_LAST = 2'(RST_CYC - 1);
   localparam logic [1:0] RST_CNT_MAX  = 2'(RST_CYC);
   // Serial frame layout, in shift-clock bit positions
   localparam logic [5:0] BIT_RW     = 6'h00;
   localparam logic [5:0] BIT_ADDR_LAST = 6'h08;
   localparam logic [5:0] BIT_DATA_LAST = 6'h10;
   localparam logic [5:0] RD_START   = 6'h21;
   localparam logic [5:0] RD_END     = 6'h29;
   localparam logic [5:0] CNT_MAX    = 6'h3F;
endpackage

// ### rtl/lui_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module lui_sync #(
   parameter int               W       = 1,
   parameter logic [W-1:0]     RST_VAL = '0
) (
   input  wire logic           clk_in,
   input  wire logic           rst_b_in,
   input  wire logic [W-1:0]   d_in,
   output logic      [W-1:0]   q_out
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         meta_r <= RST_VAL;
         q_out  <= RST_VAL;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule

// ### rtl/lui_serial_link.sv
// Serial control link logic running on the host shift clock
`timescale 1ns/1ps
module lui_serial_link (
   input  wire logic        sclk_in,
   input  wire logic        cs_b_in,
   input  wire logic        shift_edge_select_in,
   input  wire logic        serial_in_line_in,
   input  wire logic [7:0]  rd_word_in,
   output logic             serial_out_line_out,
   output logic             req_out,
   output logic             req_rd_out,
   output logic      [7:0]  req_addr_out,
   output logic      [7:0]  req_data_out
);
   logic [5:0] cnt_r;
   logic [5:0] off;
   logic       oclk;
   logic       in_rd_win;

   // Active output edge: rising when select low, falling when high
   assign oclk      = sclk_in ^ shift_edge_select_in;
   assign off       = cnt_r - lui_pkg::RD_START;
   assign in_rd_win = req_rd_out && (cnt_r >= lui_pkg::RD_START) && (cnt_r < lui_pkg::RD_END);

   // Bit counter, cleared while chip select is high
   always_ff @(posedge sclk_in or posedge cs_b_in) begin
      if (cs_b_in) begin
         cnt_r <= lui_pkg::BIT_RW;
      end else if (cnt_r != lui_pkg::CNT_MAX) begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   // Input bits sampled on rising shift clock
   always_ff @(posedge sclk_in or posedge cs_b_in) begin
      if (cs_b_in) begin
         req_rd_out   <= 1'b0;
         req_addr_out <= lui_pkg::ZERO8;
         req_data_out <= lui_pkg::ZERO8;
      end else if (cnt_r == lui_pkg::BIT_RW) begin
         req_rd_out <= serial_in_line_in;
      end else if (cnt_r <= lui_pkg::BIT_ADDR_LAST) begin
         req_addr_out <= {req_addr_out[6:0], serial_in_line_in};
      end else if (!req_rd_out && cnt_r <= lui_pkg::BIT_DATA_LAST) begin
         req_data_out <= {req_data_out[6:0], serial_in_line_in};
      end
   end

   // Request level, one per frame, ended by chip select
   always_ff @(posedge sclk_in or posedge cs_b_in) begin
      if (cs_b_in) begin
         req_out <= 1'b0;
      end else if (req_rd_out && cnt_r == lui_pkg::BIT_ADDR_LAST) begin
         req_out <= 1'b1;
      end else if (!req_rd_out && cnt_r == lui_pkg::BIT_DATA_LAST) begin
         req_out <= 1'b1;
      end
   end

   // Read data out, MSB first, on the active edge
   always_ff @(posedge oclk or posedge cs_b_in) begin
      if (cs_b_in) begin
         serial_out_line_out <= 1'b0;
      end else if (in_rd_win) begin
         serial_out_line_out <= rd_word_in[~off[2:0]];
      end
   end

   property p_addr_sample;
      @(posedge sclk_in) disable iff (cs_b_in)
      (cnt_r >= 6'h01 && cnt_r <= lui_pkg::BIT_ADDR_LAST)
         |=> req_addr_out[0] == $past(serial_in_line_in);
   endproperty
   a_addr_sample: assert property (p_addr_sample)
      else $error("serial address bit not sampled");

   property p_ser_out_bit;
      @(posedge oclk) disable iff (cs_b_in)
      in_rd_win |=> serial_out_line_out == $past(rd_word_in[~off[2:0]]);
   endproperty
   a_ser_out_bit: assert property (p_ser_out_bit)
      else $error("serial output bit wrong");
endmodule

// ### rtl/lui_host_port.sv
// Host control port: parallel and serial register access, interrupt pin, reset
`timescale 1ns/1ps
module lui_host_port (
   input  wire logic        mclk_in,
   input  wire logic        rst_b_in,
   input  wire logic        par_sel_in,
   input  wire logic        cs_b_in,
   input  wire logic        wr_b_in,
   input  wire logic        rd_b_in,
   input  wire logic [7:0]  addr_lines_in,
   input  wire logic [7:0]  bidir_bus_lines_in,
   output logic      [7:0]  bidir_bus_lines_out,
   output logic             bidir_bus_lines_oe_b_out,
   input  wire logic        sclk_in,
   input  wire logic        shift_edge_select_in,
   input  wire logic        serial_in_line_in,
   output logic             serial_out_line_out,
   input  wire logic [15:0] irq_event_in,
   output logic             irq_out,
   output logic             irq_oe_b_out,
   output logic             line_drv_hiz_out
);
   logic        rst_low_r;
   logic        rst_i;
   logic [3:0]  ctl_s;
   logic [3:0]  ctl_d_r;
   logic [15:0] bus_s;
   logic        par_s;
   logic        cs_b_s;
   logic        wr_b_s;
   logic        rd_b_s;
   logic [7:0]  addr_s;
   logic [7:0]  data_s;
   logic        wr_rise;
   logic        rd_rise;
   logic        rd_act;
   logic        ser_req;
   logic        ser_req_s;
   logic        ser_req_d_r;
   logic        ser_rise;
   logic        ser_rd;
   logic [7:0]  ser_addr;
   logic [7:0]  ser_data;
   logic [7:0]  ser_rdata_r;
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic [7:0]  mask1_r;
   logic [7:0]  mask2_r;
   logic [7:0]  gcfg_r;
   logic [15:0] stat_r;
   logic [15:0] stat_clr;
   logic [15:0] pend;
   logic [7:0]  summ;
   logic        irq_any;
   logic [1:0]  style;

   // Register read multiplexer, unmapped addresses read zero
   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      logic [7:0] v;
      v = lui_pkg::ZERO8;
      case (a)
         lui_pkg::ADDR_MASK1: v = mask1_r;
         lui_pkg::ADDR_MASK2: v = mask2_r;
         lui_pkg::ADDR_STAT1: v = stat_r[7:0];
         lui_pkg::ADDR_STAT2: v = stat_r[15:8];
         lui_pkg::ADDR_GCFG:  v = gcfg_r;
         lui_pkg::ADDR_SUMM:  v = summ;
         default:             v = lui_pkg::ZERO8;
      endcase
      return v;
   endfunction

   // Reset pin filter: remembers a low sample at the previous edge
   // Plain inverted copy of the pin, so it is known after one edge from power-up
   // One low sample alone never resets; two in a row do
   always_ff @(posedge mclk_in) begin
      rst_low_r <= !rst_b_in;
   end
   assign rst_i = !rst_b_in && rst_low_r;

   // Pin and serial request synchronisers
   lui_sync #(.W(4), .RST_VAL(4'hF)) u_sync_ctl (
      .clk_in   (mclk_in),
      .rst_b_in (!rst_i),
      .d_in     ({par_sel_in, cs_b_in, wr_b_in, rd_b_in}),
      .q_out    (ctl_s)
   );
   lui_sync #(.W(16), .RST_VAL(16'h0000)) u_sync_bus (
      .clk_in   (mclk_in),
      .rst_b_in (!rst_i),
      .d_in     ({addr_lines_in, bidir_bus_lines_in}),
      .q_out    (bus_s)
   );
   lui_sync #(.W(1), .RST_VAL(1'b0)) u_sync_req (
      .clk_in   (mclk_in),
      .rst_b_in (!rst_i),
      .d_in     (ser_req),
      .q_out    (ser_req_s)
   );

   // Serial link on the host shift clock
   lui_serial_link u_serial (
      .sclk_in              (sclk_in),
      .cs_b_in              (cs_b_in),
      .shift_edge_select_in (shift_edge_select_in),
      .serial_in_line_in    (serial_in_line_in),
      .rd_word_in           (ser_rdata_r),
      .serial_out_line_out  (serial_out_line_out),
      .req_out              (ser_req),
      .req_rd_out           (ser_rd),
      .req_addr_out         (ser_addr),
      .req_data_out         (ser_data)
   );

   assign {par_s, cs_b_s, wr_b_s, rd_b_s} = ctl_s;
   assign {addr_s, data_s} = bus_s;

   // Edge history of strobes and serial request
   always_ff @(posedge mclk_in) begin
      if (rst_i) begin
         ctl_d_r     <= 4'hF;
         ser_req_d_r <= 1'b0;
      end else begin
         ctl_d_r     <= ctl_s;
         ser_req_d_r <= ser_req_s;
      end
   end

   // Strobe decode, qualified by chip select
   assign wr_rise  = par_s && !cs_b_s && wr_b_s && !ctl_d_r[1];
   assign rd_rise  = par_s && !cs_b_s && rd_b_s && !ctl_d_r[0];
   assign rd_act   = par_s && !cs_b_s && !rd_b_s;
   assign ser_rise = !par_s && ser_req_s && !ser_req_d_r;
   assign wr_en    = wr_rise || (ser_rise && !ser_rd);
   assign wr_addr  = par_s ? addr_s : ser_addr;
   assign wr_data  = par_s ? data_s : ser_data;

   // Writable registers
   always_ff @(posedge mclk_in) begin
      if (rst_i) begin
         mask1_r <= lui_pkg::MASK_RST;
         mask2_r <= lui_pkg::MASK_RST;
         gcfg_r  <= lui_pkg::GCFG_RST;
      end else if (wr_en) begin
         if (wr_addr == lui_pkg::ADDR_MASK1) mask1_r <= wr_data;
         if (wr_addr == lui_pkg::ADDR_MASK2) mask2_r <= wr_data;
         if (wr_addr == lui_pkg::ADDR_GCFG)  gcfg_r  <= wr_data;
      end
   end

   // Serial read word, held until the next read request
   always_ff @(posedge mclk_in) begin
      if (rst_i) begin
         ser_rdata_r <= lui_pkg::ZERO8;
      end else if (ser_rise && ser_rd) begin
         ser_rdata_r <= rd_mux(ser_addr);
      end
   end

   // Parallel read drive; released outside reads
   always_ff @(posedge mclk_in) begin
      if (rst_i) begin
         bidir_bus_lines_out      <= lui_pkg::ZERO8;
         bidir_bus_lines_oe_b_out <= 1'b1;
      end else begin
         bidir_bus_lines_out      <= rd_act ? rd_mux(addr_s) : lui_pkg::ZERO8;
         bidir_bus_lines_oe_b_out <= !rd_act;
      end
   end

   // Clear-on-read: only the bits that were actually returned
   always_comb begin
      stat_clr = 16'h0000;
      if (rd_rise && addr_s == lui_pkg::ADDR_STAT1) stat_clr[7:0] = bidir_bus_lines_out;
      if (rd_rise && addr_s == lui_pkg::ADDR_STAT2) stat_clr[15:8] = bidir_bus_lines_out;
      if (ser_rise && ser_rd && ser_addr == lui_pkg::ADDR_STAT1) begin
         stat_clr[7:0] = stat_r[7:0];
      end
      if (ser_rise && ser_rd && ser_addr == lui_pkg::ADDR_STAT2) begin
         stat_clr[15:8] = stat_r[15:8];
      end
   end

   // Sticky status; a new event wins over a clear
   always_ff @(posedge mclk_in) begin
      if (rst_i) begin
         stat_r <= 16'h0000;
      end else begin
         stat_r <= (stat_r & ~stat_clr) | irq_event_in;
      end
   end

   // Unmasked pending sources
   assign pend    = stat_r & ~{mask2_r, mask1_r};
   assign irq_any = (|pend) && !gcfg_r[lui_pkg::GLB_BIT];
   assign style   = gcfg_r[lui_pkg::STYLE_LSB +: 2];

   // Per-channel summary of unmasked pending sources
   genvar c;
   generate
      for (c = 0; c < lui_pkg::NCH; c++) begin : g_summ
         assign summ[c] = pend[c] | pend[c+4] | pend[c+8] | pend[c+12];
      end
   endgenerate
   assign summ[7:4] = 4'h0;

   // Interrupt pin style
   always_ff @(posedge mclk_in) begin
      if (rst_i) begin
         irq_out      <= 1'b0;
         irq_oe_b_out <= 1'b1;
      end else begin
         unique case (style)
            lui_pkg::STY_OD_LOW: begin
               irq_out      <= 1'b0;
               irq_oe_b_out <= !irq_any;
            end
            lui_pkg::STY_PP_LOW: begin
               irq_out      <= !irq_any;
               irq_oe_b_out <= 1'b0;
            end
            default: begin
               irq_out      <= irq_any;
               irq_oe_b_out <= 1'b0;
            end
         endcase
      end
   end

   // Line drivers held in high impedance through reset
   always_ff @(posedge mclk_in) begin
      line_drv_hiz_out <= rst_i;
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_i);

   sequence s_par_write;
      wr_rise && wr_addr == lui_pkg::ADDR_MASK1;
   endsequence
   property p_write_cap;
      s_par_write |=> mask1_r == $past(data_s);
   endproperty
   a_write_cap: assert property (p_write_cap)
      else $error("parallel write not captured");

   property p_one_src;
      (|(stat_r & ~{mask2_r, mask1_r})) && !gcfg_r[lui_pkg::GLB_BIT]
         && style == lui_pkg::STY_PP_HI |=> irq_out;
   endproperty
   a_one_src: assert property (p_one_src)
      else $error("pending source does not raise request");

   property p_glb_mask;
      gcfg_r[lui_pkg::GLB_BIT] && style == lui_pkg::STY_OD_LOW |=> irq_oe_b_out;
   endproperty
   a_glb_mask: assert property (p_glb_mask)
      else $error("global mask ignored");

   property p_src_mask;
      ({mask2_r, mask1_r} == 16'hFFFF) && style == lui_pkg::STY_OD_LOW |=> irq_oe_b_out;
   endproperty
   a_src_mask: assert property (p_src_mask)
      else $error("source masks ignored");

   property p_sticky;
      (irq_event_in != 16'h0000) |=> (stat_r & $past(irq_event_in)) == $past(irq_event_in);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("event lost from status");

   property p_style_od;
      style == lui_pkg::STY_OD_LOW |=> !irq_out;
   endproperty
   a_style_od: assert property (p_style_od)
      else $error("open drain output drives high");

   sequence s_read_done;
      !rd_act ##1 !rd_act;
   endsequence
   property p_bus_release;
      s_read_done |-> bidir_bus_lines_oe_b_out;
   endproperty
   a_bus_release: assert property (p_bus_release)
      else $error("data bus driven outside a read");

   sequence s_rst_held;
      !rst_b_in [*2];
   endsequence
   property p_rst_filter;
      @(posedge mclk_in) disable iff (1'b0)
      s_rst_held |=> bidir_bus_lines_oe_b_out && irq_oe_b_out && mask1_r == lui_pkg::MASK_RST;
   endproperty
   a_rst_filter: assert property (p_rst_filter)
      else $error("held reset did not reset");

   property p_rst_hiz;
      @(posedge mclk_in) disable iff (1'b0)
      rst_i |=> line_drv_hiz_out && stat_r == 16'h0000;
   endproperty
   a_rst_hiz: assert property (p_rst_hiz)
      else $error("reset did not release drivers");

   property p_idle;
      (pend == 16'h0000) && style == lui_pkg::STY_PP_HI |=> !irq_out;
   endproperty
   a_idle: assert property (p_idle)
      else $error("request stays active with nothing pending");
endmodule

// ### tb/host_mcu_model.sv
// Host microcontroller model driving the control pins
`timescale 1ns/1ps
module host_mcu_model (
   input  wire logic       mclk_in,
   input  wire logic [7:0] bus_in,
   input  wire logic       serial_out_line_in,
   input  wire logic       shift_edge_select_in,
   output logic            cs_b_out,
   output logic            wr_b_out,
   output logic            rd_b_out,
   output logic      [7:0] addr_out,
   output logic      [7:0] data_out,
   output logic            sclk_out,
   output logic            ser_line_out
);
   // Idle: deselected, strobes high, shift clock stopped low
   initial begin
      cs_b_out = 1'b1;
      wr_b_out = 1'b1;
      rd_b_out = 1'b1;
      addr_out = 8'h00;
      data_out = 8'hA5;
      sclk_out = 1'b0;
      ser_line_out = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk_in);
   endtask

   // Write: strobe low four cycles, address and data held past it
   task automatic par_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      cs_b_out <= 1'b0;
      wr_b_out <= 1'b0;
      addr_out <= a;
      data_out <= d;
      wait_clk(4);
      wr_b_out <= 1'b1;
      wait_clk(4);
      cs_b_out <= 1'b1;
      data_out <= ~d; // Released bus shows the inverse
      wait_clk(4);
   endtask

   // Read: data taken after the fixed answer latency
   task automatic par_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_in);
      cs_b_out <= 1'b0;
      rd_b_out <= 1'b0;
      addr_out <= a;
      wait_clk(5);
      #1;
      d = bus_in;
      @(posedge mclk_in);
      rd_b_out <= 1'b1;
      wait_clk(4); // Chip select outlasts the strobe so its rise is seen
      cs_b_out <= 1'b1;
      wait_clk(5);
   endtask

   // Serial frame: rw, address, data, dummy clocks, read bits
   task automatic ser_xfer(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                           output logic [7:0] rdata);
      logic [16:0] f;
      int          n;
      f = {rd, a, wd};
      n = rd ? 41 : 17;
      rdata = 8'h00;
      #7;
      cs_b_out = 1'b0;
      for (int i = 0; i < n; i++) begin
         ser_line_out = (i < 17) ? f[16 - i] : ~ser_line_out;
         #15;
         sclk_out = 1'b1;
         if (shift_edge_select_in && i >= 33) rdata[40 - i] = serial_out_line_in;
         #15;
         sclk_out = 1'b0;
         if (!shift_edge_select_in && i >= 33) rdata[40 - i] = serial_out_line_in;
      end
      #15;
      wait_clk(4); // Frame held open until the request is taken
      #7;
      cs_b_out = 1'b1;
      ser_line_out = ~ser_line_out;
      wait_clk(6);
   endtask
endmodule

// ### tb/tb_host_port_irq_reset.sv
// Self-checking bench for the host control port
`timescale 1ns/1ps
module tb_host_port_irq_reset;
   logic            mclk;
   logic            rst_b;
   logic            par_sel;
   logic            edge_sel;
   logic [15:0]     irq_ev;
   logic [7:0]      seed_r;
   logic [7:0]      v;
   logic [3:0]      src;
   int              fails;
   int              compares;
   wire logic       cs_b, wr_b, rd_b, sclk, ser_in, ser_out, irq, irq_oe_b, hiz, oe_b;
   wire logic [7:0] addr, host_d, dut_d, bus;
   logic [7:0]      rst_addr [7] = '{lui_pkg::ADDR_MASK1, lui_pkg::ADDR_MASK2,
      lui_pkg::ADDR_STAT1, lui_pkg::ADDR_STAT2, lui_pkg::ADDR_GCFG, lui_pkg::ADDR_SUMM, 8'h55};
   logic [7:0]      rst_val [7] = '{lui_pkg::MASK_RST, lui_pkg::MASK_RST, lui_pkg::ZERO8,
      lui_pkg::ZERO8, lui_pkg::GCFG_RST, lui_pkg::ZERO8, lui_pkg::ZERO8};
   logic [1:0]      styles [3] = '{lui_pkg::STY_OD_LOW, lui_pkg::STY_PP_LOW, lui_pkg::STY_PP_HI};

   // Bus level from whichever side drives it
   assign bus = !oe_b ? dut_d : host_d;

   lui_host_port dut_u (.mclk_in(mclk), .rst_b_in(rst_b), .par_sel_in(par_sel),
      .cs_b_in(cs_b), .wr_b_in(wr_b), .rd_b_in(rd_b), .addr_lines_in(addr),
      .bidir_bus_lines_in(bus), .bidir_bus_lines_out(dut_d), .bidir_bus_lines_oe_b_out(oe_b),
      .sclk_in(sclk), .shift_edge_select_in(edge_sel), .serial_in_line_in(ser_in),
      .serial_out_line_out(ser_out), .irq_event_in(irq_ev), .irq_out(irq),
      .irq_oe_b_out(irq_oe_b), .line_drv_hiz_out(hiz));

   host_mcu_model host_u (.mclk_in(mclk), .bus_in(bus), .serial_out_line_in(ser_out),
      .shift_edge_select_in(edge_sel), .cs_b_out(cs_b), .wr_b_out(wr_b), .rd_b_out(rd_b),
      .addr_out(addr), .data_out(host_d), .sclk_out(sclk), .ser_line_out(ser_in));

   // System clock, 100 ns period
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Expected {level, enable_b} of the interrupt pin
   function automatic logic [1:0] pin_exp(input logic [1:0] st, input logic act);
      case (st)
         lui_pkg::STY_OD_LOW: return act ? 2'h0 : 2'h1;
         lui_pkg::STY_PP_LOW: return act ? 2'h0 : 2'h2;
         default:             return act ? 2'h2 : 2'h0;
      endcase
   endfunction

   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask

   // Released open-drain pin: only the enable is compared
   task automatic check_pin(input logic [1:0] st, input logic act);
      logic [1:0] m;
      #1;
      m = (st == lui_pkg::STY_OD_LOW && !act) ? 2'h1 : 2'h3;
      compares++;
      if (({irq, irq_oe_b} & m) !== (pin_exp(st, act) & m)) begin
         fails++;
         $display("wrong value at %0t: irq pin %b expected %b", $time, {irq, irq_oe_b},
                  pin_exp(st, act));
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host_u.par_rd(a, d);
      check_reg(d, exp);
   endtask

   task automatic pulse_src(input logic [3:0] s);
      @(posedge mclk);
      irq_ev[s] <= 1'b1;
      @(posedge mclk);
      irq_ev <= 16'h0000;
      repeat (4) @(posedge mclk);
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Cuts a hung run short, about eighteen times the expected length
   initial begin
      #2000000;
      fails++;
      print_verdict();
   end

   // Main sequence
   initial begin
      rst_b = 1'b0;
      par_sel = 1'b1;
      edge_sel = 1'b0;
      irq_ev = 16'h0000;
      seed_r = 8'h39;
      fails = 0;
      compares = 0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      check_reg({6'h00, hiz, oe_b}, 8'h03);
      repeat (3) @(posedge mclk);
      #1;
      check_reg({6'h00, hiz, irq_oe_b}, 8'h01);
      for (int i = 0; i < 7; i++) begin
         rd_chk(rst_addr[i], rst_val[i]);
      end
      // Random writes, read-only and unmapped places
      for (int i = 0; i < 4; i++) begin
         seed_r = lfsr_next(seed_r);
         host_u.par_wr(lui_pkg::ADDR_MASK1, seed_r);
         host_u.par_wr(lui_pkg::ADDR_MASK2, ~seed_r);
         host_u.par_wr(lui_pkg::ADDR_GCFG, {5'h00, seed_r[2:0]});
         host_u.par_wr(lui_pkg::ADDR_STAT1, seed_r);
         host_u.par_wr(8'h55, seed_r);
         rd_chk(lui_pkg::ADDR_MASK1, seed_r);
         rd_chk(lui_pkg::ADDR_MASK2, ~seed_r);
         rd_chk(lui_pkg::ADDR_GCFG, {5'h00, seed_r[2:0]});
         rd_chk(lui_pkg::ADDR_STAT1, lui_pkg::ZERO8);
         rd_chk(8'h55, lui_pkg::ZERO8);
         check_reg({7'h00, oe_b}, 8'h01);
      end
      // Serial write and read back in both edge modes
      par_sel <= 1'b0;
      for (int e = 0; e < 2; e++) begin
         repeat (4) @(posedge mclk);
         edge_sel <= e[0];
         seed_r = lfsr_next(seed_r);
         host_u.ser_xfer(1'b0, lui_pkg::ADDR_MASK1, seed_r, v);
         host_u.ser_xfer(1'b1, lui_pkg::ADDR_MASK1, 8'h00, v);
         check_reg(v, seed_r);
      end
      par_sel <= 1'b1;
      repeat (4) @(posedge mclk);
      // Interrupt pin in every style
      host_u.par_wr(lui_pkg::ADDR_MASK1, 8'h00);
      host_u.par_wr(lui_pkg::ADDR_MASK2, 8'h00);
      for (int i = 0; i < 3; i++) begin
         seed_r = lfsr_next(seed_r);
         src = seed_r[3:0];
         host_u.par_wr(lui_pkg::ADDR_GCFG, {6'h00, styles[i]});
         check_pin(styles[i], 1'b0);
         pulse_src(src);
         check_pin(styles[i], 1'b1);
         rd_chk(lui_pkg::ADDR_SUMM, 8'h01 << src[1:0]);
         rd_chk(src[3] ? lui_pkg::ADDR_STAT2 : lui_pkg::ADDR_STAT1, 8'h01 << src[2:0]);
         check_pin(styles[i], 1'b0);
      end
      // Global and individual masking of a pending source
      host_u.par_wr(lui_pkg::ADDR_GCFG, 8'h06);
      pulse_src(4'h5);
      check_pin(lui_pkg::STY_PP_HI, 1'b0);
      host_u.par_wr(lui_pkg::ADDR_GCFG, 8'h02);
      check_pin(lui_pkg::STY_PP_HI, 1'b1);
      host_u.par_wr(lui_pkg::ADDR_MASK1, 8'h20);
      check_pin(lui_pkg::STY_PP_HI, 1'b0);
      host_u.par_wr(lui_pkg::ADDR_MASK1, 8'hDF);
      check_pin(lui_pkg::STY_PP_HI, 1'b1);
      rd_chk(lui_pkg::ADDR_STAT1, 8'h20);
      // Short reset pulse ignored, long one restores defaults
      host_u.par_wr(lui_pkg::ADDR_MASK2, 8'h3C);
      rst_b <= 1'b0;
      @(posedge mclk);
      rst_b <= 1'b1;
      rd_chk(lui_pkg::ADDR_MASK2, 8'h3C);
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      check_reg({6'h00, hiz, oe_b}, 8'h03);
      @(posedge mclk);
      rst_b <= 1'b1;
      rd_chk(lui_pkg::ADDR_MASK2, lui_pkg::MASK_RST);
      print_verdict();
   end
endmodule
